// *** rtl/uart_rx_error_irq_wake.v ***
/*
 UART receive path with frame and parity error flags, a two-entry receive buffer,
 interrupt combining with address detection, and power-down pause and pin wake-up,
 reached over an AXI4-Lite slave.
 Assumes all inputs synchronous to sys_clk; uartClkOn low means the UART clock is
 stopped; the transmitter lives outside and reports its empty and idle levels.
*/
// Register access over AXI4-Lite and the register addresses are this design's own decisions.
// Notes on behaviour
// - Stop bit sampled low sets the frame error flag.
// - With two stop bits, either one low sets the frame error flag.
// - Frame error is stored with its word; reset clears it.
// - Parity error set on mismatch of odd or even type, only with parity on.
// - Interrupt request is a one-cycle low pulse on each enabled condition.
// - Sources: tx empty, tx idle, rx data, overrun, address detect, pin wake.
// - Own enables for tx sources; rx data and overrun share one enable.
// - Address detect has no flag; interrupts only while detect is enabled.
// - Clock off plus wake, uart, receiver, rx enables: falling pin edge wakes.
// - Status flags are read-only; receive and overrun flags clear only by access sequences, tx and idle flags follow hardware.
// - Detect mode: rx interrupt only when top received bit is high.
// - Detect off: rx interrupt on every received word.
// - Transmitter freezes while clock stopped and resumes afterwards.
// - Reception pauses, not aborts, during power-down.
// - Power-down leaves all registers unchanged.
// - Pin data during post-wake start-up delay is discarded.
// - Without global, multifunction and uart enables, wake gives no interrupt.
// - Wake interrupt waits until the post-wake delay has elapsed.
// - Interrupt serviced only with all three enables set and stack not full.
// - Status access then data read clears overrun; receive-available clears when a data read empties the buffer.
// - Receive buffer holds two words while a third shifts in.
`timescale 1ns/1ns
`include "uart_rx_err_consts.vh"

module uart_rx_error_irq_wake #(
   parameter WAKE_DELAY_NS = `WAKE_DELAY_NS
) (
   input wire sys_clk,
   input wire reset,
   input wire [4:0] AWADDR,
   input wire AWVALID,
   output wire AWREADY,
   input wire [31:0] WDATA,
   input wire [3:0] WSTRB,
   input wire WVALID,
   output wire WREADY,
   output reg [1:0] BRESP,
   output reg BVALID,
   input wire BREADY,
   input wire [4:0] ARADDR,
   input wire ARVALID,
   output wire ARREADY,
   output reg [31:0] RDATA,
   output reg [1:0] RRESP,
   output reg RVALID,
   input wire RREADY,
   input wire rxPin,
   input wire uartClkOn,
   input wire txBufEmpty,
   input wire txIdle,
   input wire stackFull,
   output wire txClockEnable,
   output reg irqPulse_n,
   output reg cpuVector,
   output reg wakeUp
);

   localparam WAKE_CYCLES_RAW = (WAKE_DELAY_NS * `CLK_MHZ + 999) / 1000;
   localparam [15:0] WAKE_CYCLES = (WAKE_CYCLES_RAW < 1) ? 16'd1 : WAKE_CYCLES_RAW[15:0];

   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_START = 5'h02;
   localparam [4:0] S_DATA = 5'h04;
   localparam [4:0] S_STOP1 = 5'h08;
   localparam [4:0] S_STOP2 = 5'h10;

   function mapped;
      input [4:0] a;
      begin
         mapped = (a == `REG_STATUS) || (a == `REG_CTRL_ONE) || (a == `REG_CTRL_TWO) ||
            (a == `REG_DATA) || (a == `REG_BAUD) || (a == `REG_IRQ_EN);
      end
   endfunction

   function topBit;
      input [8:0] w;
      input nine;
      begin
         topBit = nine ? w[8] : w[7];
      end
   endfunction

   reg [7:0] ctrlOne_r;
   reg [7:0] ctrlTwo_r;
   reg [7:0] baud_r;
   reg [2:0] irqEn_r;
   reg awHeld_r;
   reg [4:0] awAddr_r;
   reg wHeld_r;
   reg [7:0] wData_r;
   reg wStrb0_r;
   reg [4:0] state_r;
   reg [7:0] divCnt_r;
   reg [3:0] bitCnt_r;
   reg [8:0] shift_r;
   reg ferrAcc_r;
   reg donePulse_r;
   reg [8:0] doneWord_r;
   reg doneFerr_r;
   reg [10:0] fifoMem_r [0:1];
   reg rdPtr_r;
   reg wrPtr_r;
   reg [1:0] count_r;
   reg overrun_r;
   reg statusSeen_r;
   reg rxPrev_r;
   reg wakePend_r;
   reg [15:0] wakeCnt_r;
   reg wakeFire_r;
   reg txEmptyPrev_r;
   reg txIdlePrev_r;
   reg [31:0] rdMux;

   wire uart_enable_bit = ctrlOne_r[`C1_UART_EN];
   wire nineBit = ctrlOne_r[`C1_NINE_BIT];
   wire parityEn = ctrlOne_r[`C1_PARITY_EN];
   wire parityOdd = ctrlOne_r[`C1_PARITY_ODD];
   wire stopTwo = ctrlOne_r[`C1_STOP_TWO];
   wire receiver_enable_bit = ctrlTwo_r[`C2_RX_EN];
   wire rxIe = ctrlTwo_r[`C2_RX_IE];
   wire addrDetEn = ctrlTwo_r[`C2_ADDR_DET_EN];
   wire wakeEn = ctrlTwo_r[`C2_WAKE_EN];
   wire allEn = &irqEn_r;
   wire doWrite = awHeld_r && wHeld_r;
   wire arTake = ARVALID && ARREADY;
   wire statusRead = arTake && (ARADDR == `REG_STATUS);
   wire dataRead = arTake && (ARADDR == `REG_DATA);
   wire pop = dataRead && (count_r != 2'd0);
   wire push = donePulse_r;
   wire accept = push && ((count_r != 2'd2) || pop);
   wire overrunSet = push && !accept;
   wire [10:0] head = fifoMem_r[rdPtr_r];
   wire wakeHold = wakePend_r && uartClkOn;
   wire bitTick = (divCnt_r == 8'h00);
   wire [3:0] lastBit = nineBit ? 4'd8 : 4'd7;
   wire parityBad = parityEn && ((^doneWord_r[7:0] ^ (nineBit & doneWord_r[8])) != parityOdd);
   wire addrHit = push && topBit(doneWord_r, nineBit);

   assign AWREADY = !awHeld_r && !BVALID;
   assign WREADY = !wHeld_r && !BVALID;
   assign ARREADY = !RVALID;
   // The transmitter shares the UART clock enable, so a stopped clock freezes it in place.
   assign txClockEnable = uartClkOn;

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         awHeld_r <= 1'b0;
         awAddr_r <= 5'h00;
         wHeld_r <= 1'b0;
         wData_r <= 8'h00;
         wStrb0_r <= 1'b0;
         BVALID <= 1'b0;
         BRESP <= `RESP_OKAY;
         ctrlOne_r <= `CTRL_ONE_RST;
         ctrlTwo_r <= `CTRL_TWO_RST;
         baud_r <= `BAUD_RST;
         irqEn_r <= `IRQ_EN_RST;
      end else begin
         if (AWVALID && AWREADY) begin
            awHeld_r <= 1'b1;
            awAddr_r <= AWADDR;
         end
         if (WVALID && WREADY) begin
            wHeld_r <= 1'b1;
            wData_r <= WDATA[7:0];
            wStrb0_r <= WSTRB[0];
         end
         if (doWrite) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            BVALID <= 1'b1;
            BRESP <= mapped(awAddr_r) ? `RESP_OKAY : `RESP_SLVERR;
            // Status and data are read-only here; the flags move only by hardware.
            if (wStrb0_r) begin
               case (awAddr_r)
                  `REG_CTRL_ONE: ctrlOne_r <= {wData_r[7:1], 1'b0};
                  `REG_CTRL_TWO: ctrlTwo_r <= wData_r;
                  `REG_BAUD: baud_r <= wData_r;
                  `REG_IRQ_EN: irqEn_r <= wData_r[2:0];
                  default: ;
               endcase
            end
         end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
         end
      end
   end

   // Nothing below reacts to uartClkOn falling except by pausing, so registers survive.
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state_r <= S_IDLE;
         divCnt_r <= 8'h00;
         bitCnt_r <= 4'h0;
         shift_r <= 9'h000;
         ferrAcc_r <= 1'b0;
         donePulse_r <= 1'b0;
         doneWord_r <= 9'h000;
         doneFerr_r <= 1'b0;
         rxPrev_r <= 1'b1;
      end else begin
         donePulse_r <= 1'b0;
         if (!uart_enable_bit || !receiver_enable_bit || wakeHold) begin
            state_r <= S_IDLE;
            rxPrev_r <= rxPin;
         end else if (uartClkOn) begin
            rxPrev_r <= rxPin;
            divCnt_r <= bitTick ? baud_r : divCnt_r - 8'h01;
            case (state_r)
               S_IDLE: begin
                  if (rxPrev_r && !rxPin) begin
                     state_r <= S_START;
                     divCnt_r <= {1'b0, baud_r[7:1]};
                  end
               end
               S_START: begin
                  if (bitTick) begin
                     state_r <= rxPin ? S_IDLE : S_DATA;
                     bitCnt_r <= 4'h0;
                     shift_r <= 9'h000;
                  end
               end
               S_DATA: begin
                  if (bitTick) begin
                     shift_r[bitCnt_r] <= rxPin;
                     bitCnt_r <= bitCnt_r + 4'h1;
                     if (bitCnt_r == lastBit) begin
                        state_r <= S_STOP1;
                     end
                  end
               end
               S_STOP1: begin
                  if (bitTick) begin
                     if (stopTwo) begin
                        ferrAcc_r <= !rxPin;
                        state_r <= S_STOP2;
                     end else begin
                        doneFerr_r <= !rxPin;
                        doneWord_r <= shift_r;
                        donePulse_r <= 1'b1;
                        state_r <= S_IDLE;
                     end
                  end
               end
               S_STOP2: begin
                  if (bitTick) begin
                     doneFerr_r <= ferrAcc_r || !rxPin;
                     doneWord_r <= shift_r;
                     donePulse_r <= 1'b1;
                     state_r <= S_IDLE;
                  end
               end
               default: begin
                  state_r <= S_IDLE;
               end
            endcase
         end
      end
   end

   // Two entries plus the shift register give three words in flight.
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         fifoMem_r[0] <= 11'h000;
         fifoMem_r[1] <= 11'h000;
         rdPtr_r <= 1'b0;
         wrPtr_r <= 1'b0;
         count_r <= 2'd0;
         overrun_r <= 1'b0;
         statusSeen_r <= 1'b0;
      end else begin
         if (accept) begin
            fifoMem_r[wrPtr_r] <= {parityBad, doneFerr_r, doneWord_r};
            wrPtr_r <= !wrPtr_r;
         end
         if (pop) begin
            rdPtr_r <= !rdPtr_r;
         end
         count_r <= count_r + {1'b0, accept} - {1'b0, pop};
         if (statusRead) begin
            statusSeen_r <= 1'b1;
         end else if (dataRead) begin
            statusSeen_r <= 1'b0;
         end
         // A fresh overrun in the clearing cycle wins over the clear.
         if (overrunSet) begin
            overrun_r <= 1'b1;
         end else if (dataRead && statusSeen_r) begin
            overrun_r <= 1'b0;
         end
      end
   end

   always @* begin
      rdMux = 32'h0000_0000;
      case (ARADDR)
         `REG_STATUS: begin
            rdMux[`ST_RX_AVAIL] = (count_r != 2'd0);
            rdMux[`ST_OVERRUN] = overrun_r;
            rdMux[`ST_FRAME_ERR] = (count_r != 2'd0) && head[9];
            rdMux[`ST_PARITY_ERR] = (count_r != 2'd0) && head[10];
            rdMux[`ST_RX_IDLE] = (state_r == S_IDLE);
            rdMux[`ST_TX_EMPTY] = txBufEmpty;
            rdMux[`ST_TX_IDLE] = txIdle;
         end
         `REG_CTRL_ONE: rdMux[7:0] = {ctrlOne_r[7:1], head[8]};
         `REG_CTRL_TWO: rdMux[7:0] = ctrlTwo_r;
         `REG_DATA: rdMux[7:0] = head[7:0];
         `REG_BAUD: rdMux[7:0] = baud_r;
         `REG_IRQ_EN: rdMux[2:0] = irqEn_r;
         default: rdMux = 32'h0000_0000;
      endcase
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         RVALID <= 1'b0;
         RDATA <= 32'h0000_0000;
         RRESP <= `RESP_OKAY;
      end else if (arTake) begin
         RVALID <= 1'b1;
         RDATA <= rdMux;
         RRESP <= mapped(ARADDR) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (RVALID && RREADY) begin
         RVALID <= 1'b0;
      end
   end

   // Wake-up: the edge is seen with the clock stopped; the interrupt waits for the delay.
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wakePend_r <= 1'b0;
         wakeCnt_r <= 16'h0000;
         wakeFire_r <= 1'b0;
         wakeUp <= 1'b0;
      end else begin
         wakeFire_r <= 1'b0;
         wakeUp <= 1'b0;
         if (!uartClkOn && wakeEn && uart_enable_bit && receiver_enable_bit && rxIe && rxPrev_r && !rxPin &&
               !wakePend_r) begin
            wakeUp <= 1'b1;
            wakePend_r <= 1'b1;
            wakeCnt_r <= 16'h0000;
         end else if (wakeHold) begin
            wakeCnt_r <= wakeCnt_r + 16'h0001;
            if (wakeCnt_r == WAKE_CYCLES - 16'h0001) begin
               wakePend_r <= 1'b0;
               wakeFire_r <= 1'b1;
            end
         end
      end
   end

   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         txEmptyPrev_r <= 1'b0;
         txIdlePrev_r <= 1'b0;
         irqPulse_n <= 1'b1;
         cpuVector <= 1'b0;
      end else begin : irqBlock
         reg evtTxEmpty;
         reg evtTxIdle;
         reg evtRx;
         reg evtOverrun;
         reg evtAddr;
         reg evtWake;
         reg anyEvt;
         evtTxEmpty = txBufEmpty && !txEmptyPrev_r && ctrlTwo_r[`C2_TX_EMPTY_IE];
         evtTxIdle = txIdle && !txIdlePrev_r && ctrlTwo_r[`C2_TX_IDLE_IE];
         evtRx = push && rxIe && (!addrDetEn || topBit(doneWord_r, nineBit));
         evtOverrun = overrunSet && rxIe;
         evtAddr = addrHit && addrDetEn;
         evtWake = wakeFire_r && allEn;
         anyEvt = (uartClkOn && (evtTxEmpty || evtTxIdle || evtRx || evtOverrun || evtAddr))
            || evtWake;
         if (uartClkOn) begin
            txEmptyPrev_r <= txBufEmpty;
            txIdlePrev_r <= txIdle;
         end
         irqPulse_n <= !anyEvt;
         cpuVector <= anyEvt && allEn && !stackFull;
      end
   end

endmodule

// *** rtl/uart_rx_err_consts.vh ***
/*
 Constants for the receive error, interrupt and wake-up block: register offsets,
 field positions, reset values and timing figures.
 Assumes inclusion by bare name from the design file.
*/
`ifndef UART_RX_ERR_CONSTS_VH
`define UART_RX_ERR_CONSTS_VH

`define ADDR_W 5
`define REG_STATUS 5'h00
`define REG_CTRL_ONE 5'h04
`define REG_CTRL_TWO 5'h08
`define REG_DATA 5'h0c
`define REG_BAUD 5'h10
`define REG_IRQ_EN 5'h14

`define ST_RX_AVAIL 0
`define ST_OVERRUN 1
`define ST_FRAME_ERR 2
`define ST_PARITY_ERR 3
`define ST_RX_IDLE 4
`define ST_TX_EMPTY 5
`define ST_TX_IDLE 6

`define C1_RX8 0
`define C1_STOP_TWO 3
`define C1_PARITY_ODD 4
`define C1_PARITY_EN 5
`define C1_NINE_BIT 6
`define C1_UART_EN 7

`define C2_TX_EMPTY_IE 0
`define C2_TX_IDLE_IE 1
`define C2_RX_IE 2
`define C2_WAKE_EN 3
`define C2_ADDR_DET_EN 4
`define C2_RX_EN 6

`define IE_GLOBAL 0
`define IE_MULTIFUNC 1
`define IE_UART 2

`define CTRL_ONE_RST 8'h00
`define CTRL_TWO_RST 8'h00
`define BAUD_RST 8'h00
`define IRQ_EN_RST 3'h0

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`define CLK_MHZ 125
`define WAKE_DELAY_NS 1000

`endif

// *** tb/uart_rx_error_irq_wake_monitor.sv ***
/* Port checks for the receive error, interrupt and wake block.
 Assumes a bind to the design top and an 8 ns sys_clk. */
`timescale 1ns/1ns
module uart_rx_error_irq_wake_monitor #(
   parameter WAKE_DELAY_NS = 1000
) (
   input wire sys_clk,
   input wire reset,
   input wire rxPin,
   input wire uartClkOn,
   input wire txBufEmpty,
   input wire txIdle,
   input wire stackFull,
   input wire txClockEnable,
   input wire irqPulse_n,
   input wire cpuVector,
   input wire wakeUp
);
   localparam int WakeCycles = WAKE_DELAY_NS / 8;
   logic woke_r;
   int delayCnt_r;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);
   // The quiet window ends a few cycles early to allow for pulse latency.
   always @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         woke_r <= 1'b0;
         delayCnt_r <= 0;
      end else begin
         if (wakeUp)
            woke_r <= 1'b1;
         else if (delayCnt_r > WakeCycles)
            woke_r <= 1'b0;
         if (!uartClkOn || !woke_r)
            delayCnt_r <= 0;
         else
            delayCnt_r <= delayCnt_r + 1;
      end
   end
   // Three cycles, so that a wake interrupt launched just before the clock stops is excused.
   sequence s_offThree;
      !uartClkOn ##1 !uartClkOn ##1 !uartClkOn;
   endsequence
   property p_clkGate;
      txClockEnable == uartClkOn;
   endproperty
   property p_irqOne;
      $fell(irqPulse_n) |=> irqPulse_n;
   endproperty
   property p_vecStack;
      cpuVector |-> !$past(stackFull);
   endproperty
   property p_wakeOne;
      wakeUp |=> !wakeUp;
   endproperty
   property p_wakeOff;
      wakeUp |-> !$past(uartClkOn) && !$past(rxPin);
   endproperty
   property p_offQuiet;
      s_offThree |-> irqPulse_n;
   endproperty
   property p_wakeQuiet;
      wakeUp |-> irqPulse_n;
   endproperty
   property p_wakeDelay;
      woke_r && uartClkOn && delayCnt_r < WakeCycles - 4 && txIdle == $past(txIdle, 2)
         && txBufEmpty == $past(txBufEmpty, 2) |-> irqPulse_n;
   endproperty
   a_clkGate: assert property (p_clkGate)
      else $error("clock enable differs");
   a_irqOne: assert property (p_irqOne)
      else $error("irq pulse too long");
   a_vecStack: assert property (p_vecStack)
      else $error("vector with stack full");
   a_wakeOne: assert property (p_wakeOne)
      else $error("wake pulse too long");
   a_wakeOff: assert property (p_wakeOff)
      else $error("wake without clock off and pin low");
   a_offQuiet: assert property (p_offQuiet)
      else $error("irq while clock off");
   a_wakeQuiet: assert property (p_wakeQuiet)
      else $error("irq with wake");
   a_wakeDelay: assert property (p_wakeDelay)
      else $error("irq inside wake delay");
endmodule
bind uart_rx_error_irq_wake uart_rx_error_irq_wake_monitor #(.WAKE_DELAY_NS(WAKE_DELAY_NS)) i_mon (
   .sys_clk, .reset, .rxPin, .uartClkOn, .txBufEmpty, .txIdle, .stackFull, .txClockEnable,
   .irqPulse_n, .cpuVector, .wakeUp);

// *** tb/serial_tx_model.sv ***
/* Remote serial transmitter on the receive pin, idle high.
 Assumes eight sys_clk cycles a bit; it stalls while run is low. */
`timescale 1ns/1ns
module serial_tx_model #(
   parameter BIT_CYCLES = 8
) (
   input wire sys_clk,
   input wire run,
   output logic rxPin
);
   initial rxPin = 1'b1;
   // Bit zero is the start bit; the line returns high after the last bit.
   task automatic send(input logic [12:0] f, input int len);
      int c;
      for (int i = 0; i < len; i++) begin
         rxPin <= f[i];
         c = 0;
         while (c < BIT_CYCLES) begin
            @(posedge sys_clk);
            if (run)
               c++;
         end
      end
      rxPin <= 1'b1;
   endtask
endmodule

// *** tb/tb.sv ***
/* Self-checking bench for the receive error, interrupt and wake block.
 Assumes the design top, its constants header and the serial model. */
`timescale 1ns/1ns
`include "uart_rx_err_consts.vh"
module tb;
   logic sys_clk = 0, reset = 1, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
   logic uartClkOn = 1, txBufEmpty = 0, txIdle = 0, stackFull = 0, modelRun = 1, fe, pe;
   logic [4:0] AWADDR = 0, ARADDR = 0;
   logic [31:0] WDATA = 0, d;
   logic [8:0] w;
   logic [7:0] c;
   logic [1:0] r, s, bResp;
   logic [7:0] cfg[6] = '{8'h80, 8'h80, 8'ha8, 8'ha8, 8'hf0, 8'hc0};
   logic [1:0] stp[6] = '{2'b11, 2'b10, 2'b11, 2'b01, 2'b11, 2'b11};
   wire AWREADY, WREADY, BVALID, ARREADY, RVALID, rxPin, irqPulse_n, cpuVector, wakeUp;
   wire [1:0] BRESP, RRESP;
   wire [31:0] RDATA;
   int numErrors = 0, checkCount = 0, irqN = 0, vecN = 0, wakeN = 0, k, j, i0, v0, w0;
   int expQ[$];
   uart_rx_error_irq_wake #(.WAKE_DELAY_NS(800)) i_dut (.sys_clk, .reset, .AWADDR, .AWVALID,
      .AWREADY, .WDATA, .WSTRB(4'h1), .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
      .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .rxPin, .uartClkOn, .txBufEmpty,
      .txIdle, .stackFull, .txClockEnable(), .irqPulse_n, .cpuVector, .wakeUp);
   serial_tx_model i_tx (.sys_clk, .run(modelRun), .rxPin);
   initial forever #4 sys_clk = ~sys_clk;
   initial begin
      tick(60000);
      numErrors++;
      closeOut();
   end
   always @(posedge sys_clk) begin
      irqN += !reset && !irqPulse_n;
      vecN += !reset && cpuVector;
      wakeN += !reset && wakeUp;
   end
   task chk(input string n, input logic [31:0] seen, exp);
      checkCount++;
      if (seen !== exp) begin
         numErrors++;
         $display("wrong value %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task closeOut;
      $display("checks %0d errors %0d", checkCount, numErrors);
      if (numErrors == 0 && checkCount > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task wr(input logic [4:0] a, input logic [7:0] v);
      int i;
      logic aw, wv, bv;
      @(posedge sys_clk);
      AWADDR <= a;
      WDATA <= {24'h0, v};
      AWVALID <= 1;
      WVALID <= 1;
      BREADY <= 1;
      bv = 0;
      // Handshakes are judged on values settled before the next rising edge, free of races.
      for (i = 0; i < 50 && !bv; i++) begin
         @(negedge sys_clk);
         aw = AWVALID && AWREADY;
         wv = WVALID && WREADY;
         bv = BVALID;
         bResp = BRESP;
         @(posedge sys_clk);
         if (aw)
            AWVALID <= 0;
         if (wv)
            WVALID <= 0;
      end
      BREADY <= 0;
      if (!bv) begin
         numErrors++;
         closeOut();
      end
   endtask
   task rd(input logic [4:0] a);
      int i;
      logic ar, rv;
      @(posedge sys_clk);
      ARADDR <= a;
      ARVALID <= 1;
      RREADY <= 1;
      rv = 0;
      for (i = 0; i < 50 && !rv; i++) begin
         @(negedge sys_clk);
         ar = ARVALID && ARREADY;
         rv = RVALID;
         d = RDATA;
         r = RRESP;
         @(posedge sys_clk);
         if (ar)
            ARVALID <= 0;
      end
      RREADY <= 0;
      if (!rv) begin
         numErrors++;
         closeOut();
      end
   endtask
   task rc(input logic [4:0] a, input logic [7:0] m, e, input string n);
      rd(a);
      chk(n, d & {24'h0, m}, {24'h0, e});
   endtask
   task frame(input logic [8:0] v, input logic [7:0] f, input logic [1:0] t);
      int n;
      n = f[`C1_NINE_BIT] ? 9 : 8;
      i_tx.send(({11'h0, t} << (n + 1)) | {3'h0, v, 1'b0}, n + 2 + f[`C1_STOP_TWO]);
   endtask
   task rxChk;
      int e;
      e = expQ.pop_front();
      rc(`REG_STATUS, 8'h0d, {4'h0, e[10:9], 2'b01}, "status");
      rc(`REG_CTRL_ONE, 8'h01, {7'h0, e[8]}, "ninth bit");
      rc(`REG_DATA, 8'hff, e[7:0], "data");
   endtask
   task rxWord(input logic [7:0] f);
      w = 9'($urandom);
      if (!f[`C1_NINE_BIT])
         w[8] = 0;
   endtask
   initial begin
      tick(3);
      reset <= 0;
      void'($urandom(20161));
      rc(`REG_CTRL_ONE, 8'hff, `CTRL_ONE_RST, "reset c1");
      rc(`REG_CTRL_TWO, 8'hff, `CTRL_TWO_RST, "reset c2");
      rc(`REG_BAUD, 8'hff, `BAUD_RST, "reset baud");
      rc(`REG_IRQ_EN, 8'h07, `IRQ_EN_RST, "reset ie");
      rd(5'h1c);
      chk("unmapped", {r, d[29:0]}, {`RESP_SLVERR, 30'h0});
      wr(`REG_BAUD, 8'h07);
      wr(`REG_IRQ_EN, 8'h07);
      wr(`REG_CTRL_TWO, 8'h44);
      wr(`REG_STATUS, 8'hff);
      chk("status resp", bResp, `RESP_OKAY);
      wr(5'h1c, 8'hff);
      chk("unmapped resp", bResp, `RESP_SLVERR);
      rc(`REG_STATUS, 8'h0f, 8'h00, "status write");
      $display("test registers done");
      for (k = 0; k < 6; k++) begin
         c = cfg[k];
         s = stp[k];
         wr(`REG_CTRL_ONE, c);
         stackFull <= 1'($urandom);
         rxWord(c);
         fe = !s[0] || (c[`C1_STOP_TWO] && !s[1]);
         pe = c[`C1_PARITY_EN] & (^w ^ c[`C1_PARITY_ODD]);
         expQ.push_back({pe, fe, w});
         i0 = irqN;
         v0 = vecN;
         frame(w, c, s);
         tick(6);
         chk("irq", irqN - i0, 1);
         chk("vector", vecN - v0, !stackFull);
         rxChk();
      end
      stackFull <= 0;
      $display("test errors done");
      wr(`REG_CTRL_ONE, 8'h80);
      i0 = irqN;
      for (j = 0; j < 3; j++) begin
         rxWord(8'h80);
         if (j < 2)
            expQ.push_back(w);
         frame(w, 8'h80, 2'b11);
         tick(1);
      end
      tick(5);
      chk("overrun irq", irqN - i0, 3);
      rc(`REG_STATUS, 8'h03, 8'h03, "overrun");
      rxChk();
      rc(`REG_STATUS, 8'h03, 8'h01, "overrun clear");
      rxChk();
      rc(`REG_STATUS, 8'h01, 8'h00, "empty");
      $display("test overrun done");
      wr(`REG_CTRL_TWO, 8'h54);
      for (k = 0; k < 4; k++) begin
         c = k[1] ? 8'hc0 : 8'h80;
         wr(`REG_CTRL_ONE, c);
         rxWord(c);
         w[k[1] ? 8 : 7] = k[0];
         expQ.push_back(w);
         i0 = irqN;
         frame(w, c, 2'b11);
         tick(6);
         chk("address irq", irqN - i0, k[0]);
         rxChk();
      end
      $display("test address done");
      for (k = 0; k < 4; k++) begin
         wr(`REG_CTRL_TWO, k[0] ? 8'h02 : 8'h01);
         i0 = irqN;
         if (k[1])
            txIdle <= 1;
         else
            txBufEmpty <= 1;
         tick(4);
         chk("tx irq", irqN - i0, k[0] == k[1]);
         txIdle <= 0;
         txBufEmpty <= 0;
      end
      $display("test transmit done");
      wr(`REG_CTRL_ONE, 8'h80);
      wr(`REG_CTRL_TWO, 8'h44);
      rxWord(8'h80);
      expQ.push_back(w);
      fork
         frame(w, 8'h80, 2'b11);
         begin
            tick(30);
            uartClkOn <= 0;
            modelRun <= 0;
            rc(`REG_BAUD, 8'hff, 8'h07, "baud held");
            rc(`REG_CTRL_TWO, 8'hff, 8'h44, "c2 held");
            tick(40);
            uartClkOn <= 1;
            modelRun <= 1;
         end
      join
      tick(6);
      rxChk();
      $display("test pause done");
      for (k = 0; k < 2; k++) begin
         wr(`REG_IRQ_EN, k ? 8'h00 : 8'h07);
         wr(`REG_CTRL_TWO, 8'h4c);
         rc(`REG_STATUS, 8'h01, 8'h00, "idle first");
         uartClkOn <= 0;
         tick(2);
         i0 = irqN;
         v0 = vecN;
         w0 = wakeN;
         fork
            frame(9'($urandom), 8'h80, 2'b11);
            begin
               tick(3);
               uartClkOn <= 1;
            end
         join
         tick(110);
         chk("wake", wakeN - w0, 1);
         chk("wake irq", irqN - i0, k == 0);
         chk("wake vector", vecN - v0, k == 0);
         rc(`REG_STATUS, 8'h01, 8'h00, "discarded");
      end
      $display("test wake done");
      closeOut();
   end
endmodule
